// File: rtl/wdrg_top.sv
`timescale 1ns/10ps

// Functional notes
// - enabled watchdog overflow in normal running causes a full device reset
// - enable key pattern 10101B disables the watchdog
// - enable key pattern 01010B enables the watchdog
// - any other enable key resets the device after 2 to 3 slow ticks
// - enable key holds 01010B after power-on
// - normal-mode timeout resets the device and sets the timeout flag
// - low-power timeout sets timeout flag and resets only PC and SP
// - low level on the external reset pin clears the watchdog count when pin key AAh selects reset input
// - writing an invalid enable key clears the watchdog count
// - halt instruction clears the watchdog count
// - timeout ratios span 2^8 up to 2^18 of the source clock
// - power-on reset forces the program counter to zero
// - power-on reset sets all port data and direction registers high
// - pin key 55h selects I/O, AAh selects external reset input
// - any other pin key resets the device after 2 to 3 slow ticks
// - pin key holds 55h after power-on
// - after external reset release, wait a start-up delay with execution held
// - external pin reset leaves some registers unchanged, unlike power-on
// - supply drop causes a full reset and also reloads the enable key and pin key registers
// - three-bit select chooses the sub clock division ratio
// - corrupted enable key reset sets the watchdog key fault flag
// - corrupted pin key reset sets the pin key fault flag
module wdrg_top import wdrg_pkg::*; #(
	parameter int unsigned LIRC_DIV = WDRG_LIRC_DIV,
	parameter int unsigned RSTD_CYCLES = WDRG_RSTD_CYCLES
) (
	// clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// core status and pins
	input wire logic low_power_i,
	input wire logic ext_nrst_pin_i,
	input wire logic supply_drop_i,
	// reset outputs
	output logic device_reset_o,
	output logic por_reset_o,
	output logic port_preset_o,
	output logic pc_zero_o,
	output logic pc_sp_reset_o,
	output logic ext_pin_is_reset_o,
	output logic timeout_flag_o
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [15:0] div_q;
	logic slow_tick;
	logic [2:0] pin_sync_q;
	logic [2:0] drop_sync_q;
	logic pin_low_q;
	logic drop_q;
	logic [7:0] watchdog_control_reg_q;
	logic [7:0] pin_function_key_reg_q;
	logic [4:0] wdt_enable_key;
	logic [2:0] timeout_select;
	logic wdt_key_ok;
	logic pin_key_ok;
	logic wdt_enabled;
	logic pin_is_reset;
	logic [1:0] wkey_cnt_q;
	logic [1:0] pkey_cnt_q;
	logic wkey_fault_ev;
	logic pkey_fault_ev;
	logic watchdog_key_fault_flag_q;
	logic pin_key_fault_flag_q;
	logic timeout_flag_q;
	logic [WDRG_CNT_W-1:0] wdt_cnt_q;
	logic [WDRG_CNT_W-1:0] wdt_limit;
	logic wdt_ovf;
	logic ovf_full;
	logic ovf_light;
	logic ack_q;
	logic [31:0] dat_q;
	logic req;
	logic wr_now;
	logic wr_ctrl;
	logic wr_pin;
	logic wr_status;
	logic wr_cmd;
	logic clr_instr;
	logic halt_instr;
	logic ext_rst_level;
	logic full_event;
	wdrg_state_t state_q;
	logic [15:0] delay_q;
	logic por_q;
	logic pc_sp_q;

	// ---------------------------------------------------------------
	// slow oscillator tick, also the sub clock
	// ---------------------------------------------------------------

	// divider producing a one-cycle enable at the slow oscillator rate
	always_ff @(posedge clk_i) begin
		if (rst_i || div_q == 16'(LIRC_DIV - 1)) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	assign slow_tick = (div_q == 16'(LIRC_DIV - 1));

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------

	// three-stage capture; only stages two and three are compared
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_sync_q <= 3'h7;
			drop_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], ext_nrst_pin_i};
			drop_sync_q <= {drop_sync_q[1:0], supply_drop_i};
		end
	end

	// filtered levels update once the last two stages agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_low_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			if (pin_sync_q[1] == pin_sync_q[2]) begin
				pin_low_q <= ~pin_sync_q[2];
			end
			if (drop_sync_q[1] == drop_sync_q[2]) begin
				drop_q <= drop_sync_q[2];
			end
		end
	end

	// ---------------------------------------------------------------
	// wishbone decode
	// ---------------------------------------------------------------
	assign req = cyc_i && stb_i;
	assign wr_now = req && we_i && ack_q && sel_i[0];
	assign wr_ctrl = wr_now && adr_i == WDRG_OFS_WDT_CTRL;
	assign wr_pin = wr_now && adr_i == WDRG_OFS_PIN_KEY;
	assign wr_status = wr_now && adr_i == WDRG_OFS_STATUS;
	assign wr_cmd = wr_now && adr_i == WDRG_OFS_CMD;
	assign clr_instr = wr_cmd && dat_i[WDRG_CMD_CLR];
	assign halt_instr = wr_cmd && dat_i[WDRG_CMD_HALT];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end
	assign ack_o = ack_q;

	// read data captured as ack rises; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (req && !ack_q) begin
			unique case (adr_i)
				WDRG_OFS_WDT_CTRL: dat_q <= {24'h000000, watchdog_control_reg_q};
				WDRG_OFS_PIN_KEY: dat_q <= {24'h000000, pin_function_key_reg_q};
				WDRG_OFS_STATUS: dat_q <= {27'h0000000, timeout_flag_q,
					pin_key_fault_flag_q, 2'h0, watchdog_key_fault_flag_q};
				default: dat_q <= 32'h0000_0000;
			endcase
		end
	end
	assign dat_o = dat_q;

	// ---------------------------------------------------------------
	// protected registers
	// ---------------------------------------------------------------
	assign wdt_enable_key = watchdog_control_reg_q[7:WDRG_KEY_LSB];
	assign timeout_select = watchdog_control_reg_q[WDRG_KEY_LSB-1:0];
	assign wdt_key_ok = (wdt_enable_key == WDRG_WDT_KEY_ON) ||
		(wdt_enable_key == WDRG_WDT_KEY_OFF);
	assign wdt_enabled = (wdt_enable_key == WDRG_WDT_KEY_ON);
	assign pin_key_ok = (pin_function_key_reg_q == WDRG_PIN_KEY_IO) ||
		(pin_function_key_reg_q == WDRG_PIN_KEY_RST);
	assign pin_is_reset = (pin_function_key_reg_q == WDRG_PIN_KEY_RST);
	assign ext_pin_is_reset_o = pin_is_reset;

	// control register; an enable key fault or supply drop reloads it
	always_ff @(posedge clk_i) begin
		if (rst_i || wkey_fault_ev || drop_q) begin
			watchdog_control_reg_q <= WDRG_WDT_CTRL_RST;
		end else if (wr_ctrl) begin
			watchdog_control_reg_q <= dat_i[7:0];
		end
	end

	// pin key register; survives pin and watchdog resets
	always_ff @(posedge clk_i) begin
		if (rst_i || pkey_fault_ev || drop_q) begin
			pin_function_key_reg_q <= WDRG_PIN_KEY_RSTV;
		end else if (wr_pin) begin
			pin_function_key_reg_q <= dat_i[7:0];
		end
	end

	// ---------------------------------------------------------------
	// key checkers on the slow tick
	// ---------------------------------------------------------------

	// count slow ticks while a key is bad; fault fires on the third, 2 to 3 periods on
	always_ff @(posedge clk_i) begin
		if (rst_i || wdt_key_ok || wkey_fault_ev) begin
			wkey_cnt_q <= 2'h0;
		end else if (slow_tick) begin
			wkey_cnt_q <= wkey_cnt_q + 2'h1;
		end
		if (rst_i || pin_key_ok || pkey_fault_ev) begin
			pkey_cnt_q <= 2'h0;
		end else if (slow_tick) begin
			pkey_cnt_q <= pkey_cnt_q + 2'h1;
		end
	end
	assign wkey_fault_ev = !wdt_key_ok && slow_tick &&
		(wkey_cnt_q == WDRG_KEY_FAULT_TICKS);
	assign pkey_fault_ev = !pin_key_ok && slow_tick &&
		(pkey_cnt_q == WDRG_KEY_FAULT_TICKS);

	// fault flags: hardware sets, software clears by writing zero, set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			watchdog_key_fault_flag_q <= 1'b0;
			pin_key_fault_flag_q <= 1'b0;
		end else begin
			if (wkey_fault_ev) begin
				watchdog_key_fault_flag_q <= 1'b1;
			end else if (wr_status && !dat_i[WDRG_ST_WKF]) begin
				watchdog_key_fault_flag_q <= 1'b0;
			end
			if (pkey_fault_ev) begin
				pin_key_fault_flag_q <= 1'b1;
			end else if (wr_status && !dat_i[WDRG_ST_PKF]) begin
				pin_key_fault_flag_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// watchdog counter
	// ---------------------------------------------------------------

	// division ratio per select code, 2^8 to 2^18
	always_comb begin
		unique case (timeout_select)
			3'h0: wdt_limit = WDRG_CNT_W'(1) << 8;
			3'h1: wdt_limit = WDRG_CNT_W'(1) << 10;
			3'h2: wdt_limit = WDRG_CNT_W'(1) << 12;
			3'h3: wdt_limit = WDRG_CNT_W'(1) << 14;
			3'h4: wdt_limit = WDRG_CNT_W'(1) << 15;
			3'h5: wdt_limit = WDRG_CNT_W'(1) << 16;
			3'h6: wdt_limit = WDRG_CNT_W'(1) << 17;
			3'h7: wdt_limit = WDRG_CNT_W'(1) << 18;
		endcase
	end

	assign ext_rst_level = pin_is_reset && pin_low_q;
	assign wdt_ovf = wdt_enabled && slow_tick && state_q == WDRG_RUN &&
		(wdt_cnt_q == wdt_limit - WDRG_CNT_W'(1));
	assign ovf_full = wdt_ovf && !low_power_i;
	assign ovf_light = wdt_ovf && low_power_i;

	// count sub clock ticks; several sources clear the count
	always_ff @(posedge clk_i) begin
		if (rst_i || ext_rst_level || state_q != WDRG_RUN) begin
			wdt_cnt_q <= '0;
		end else if (wr_ctrl && !((dat_i[7:WDRG_KEY_LSB] == WDRG_WDT_KEY_ON) ||
			(dat_i[7:WDRG_KEY_LSB] == WDRG_WDT_KEY_OFF))) begin
			wdt_cnt_q <= '0;
		end else if (clr_instr || halt_instr || wdt_ovf) begin
			wdt_cnt_q <= '0;
		end else if (wdt_enabled && slow_tick) begin
			wdt_cnt_q <= wdt_cnt_q + WDRG_CNT_W'(1);
		end
	end

	// timeout flag: set by any overflow, cleared by the clear instruction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_flag_q <= 1'b0;
		end else if (wdt_ovf) begin
			timeout_flag_q <= 1'b1;
		end else if (clr_instr) begin
			timeout_flag_q <= 1'b0;
		end
	end
	assign timeout_flag_o = timeout_flag_q;

	// one-cycle program counter and stack pointer reset in low power
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_sp_q <= 1'b0;
		end else begin
			pc_sp_q <= ovf_light;
		end
	end
	assign pc_sp_reset_o = pc_sp_q;

	// ---------------------------------------------------------------
	// reset sequencer
	// ---------------------------------------------------------------
	assign full_event = ovf_full || wkey_fault_ev || pkey_fault_ev ||
		ext_rst_level || drop_q;

	// hold while a level source stays active, then run the start-up delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= WDRG_DELAY;
			delay_q <= 16'h0000;
		end else begin
			unique case (state_q)
				WDRG_RUN: begin
					if (full_event) begin
						state_q <= WDRG_HOLD;
					end
				end
				WDRG_HOLD: begin
					delay_q <= 16'h0000;
					if (!ext_rst_level && !drop_q) begin
						state_q <= WDRG_DELAY;
					end
				end
				WDRG_DELAY: begin
					if (ext_rst_level || drop_q) begin
						state_q <= WDRG_HOLD;
					end else if (delay_q == 16'(RSTD_CYCLES - 1)) begin
						state_q <= WDRG_RUN;
					end else begin
						delay_q <= delay_q + 16'h0001;
					end
				end
			endcase
		end
	end

	// power-on marker, kept only across the power-on start-up delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_q <= 1'b1;
		end else if (state_q == WDRG_RUN) begin
			por_q <= 1'b0;
		end
	end

	// reset outputs: every device reset zeroes the PC; only power-on presets ports
	assign device_reset_o = (state_q != WDRG_RUN);
	assign pc_zero_o = (state_q != WDRG_RUN);
	// gated by the sequencer so the marker never outlives the device reset
	assign por_reset_o = por_q && (state_q != WDRG_RUN);
	assign port_preset_o = por_q && (state_q != WDRG_RUN);

endmodule

// File: shared/wdrg_pkg.sv
package wdrg_pkg;

	// ---------------------------------------------------------------
	// clock and slow oscillator rates
	// ---------------------------------------------------------------
	localparam int unsigned WDRG_CLK_HZ = 50_000_000;
	localparam int unsigned WDRG_LIRC_HZ = 32_000;
	localparam int unsigned WDRG_LIRC_DIV = WDRG_CLK_HZ / WDRG_LIRC_HZ;

	// start-up delay after a reset source is released
	localparam int unsigned WDRG_RSTD_TIME_US = 16;
	localparam int unsigned WDRG_RSTD_CYCLES = (WDRG_RSTD_TIME_US * (WDRG_CLK_HZ / 1_000_000) > 0)
		? WDRG_RSTD_TIME_US * (WDRG_CLK_HZ / 1_000_000) : 1;

	// slow oscillator ticks before a corrupted key resets the device
	localparam logic [1:0] WDRG_KEY_FAULT_TICKS = 2'h2;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] WDRG_OFS_WDT_CTRL = 4'h0;
	localparam logic [3:0] WDRG_OFS_PIN_KEY = 4'h4;
	localparam logic [3:0] WDRG_OFS_STATUS = 4'h8;
	localparam logic [3:0] WDRG_OFS_CMD = 4'hC;

	// ---------------------------------------------------------------
	// field layout and values
	// ---------------------------------------------------------------
	localparam int unsigned WDRG_KEY_LSB = 3;
	localparam logic [4:0] WDRG_WDT_KEY_OFF = 5'h15;
	localparam logic [4:0] WDRG_WDT_KEY_ON = 5'h0A;
	localparam logic [7:0] WDRG_PIN_KEY_IO = 8'h55;
	localparam logic [7:0] WDRG_PIN_KEY_RST = 8'hAA;
	localparam logic [7:0] WDRG_WDT_CTRL_RST = 8'h53;
	localparam logic [7:0] WDRG_PIN_KEY_RSTV = 8'h55;

	// status bits
	localparam int unsigned WDRG_ST_WKF = 0;
	localparam int unsigned WDRG_ST_PKF = 3;
	localparam int unsigned WDRG_ST_TMO = 4;

	// command bits
	localparam int unsigned WDRG_CMD_CLR = 0;
	localparam int unsigned WDRG_CMD_HALT = 1;

	// watchdog counter width covers the longest ratio, 2^18
	localparam int unsigned WDRG_CNT_W = 19;

	// reset sequencer states
	typedef enum logic [1:0] {
		WDRG_RUN,
		WDRG_HOLD,
		WDRG_DELAY
	} wdrg_state_t;

endpackage

// File: sim/wdrg_checker.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// reset guard checker
// ---------------------------------------------------------------
module wdrg_checker #(
	parameter int unsigned RSTD_CYCLES = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus handshake
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// mode and reset outputs
	input wire logic low_power_i,
	input wire logic device_reset_o,
	input wire logic por_reset_o,
	input wire logic port_preset_o,
	input wire logic pc_zero_o,
	input wire logic pc_sp_reset_o,
	input wire logic timeout_flag_o
);
	// one clock domain for every check
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus ack missing or too long");
	a_por_group: assert property (
		por_reset_o |-> port_preset_o && pc_zero_o && device_reset_o)
		else $error("power-on outputs disagree");
	a_pc_zero: assert property (pc_zero_o == device_reset_o)
		else $error("pc zero not tied to device reset");
	a_por_entry: assert property ($fell(rst_i) |-> por_reset_o && device_reset_o)
		else $error("power-on reset not held after release");
	a_delay_len: assert property (
		$fell(device_reset_o) |-> $past(device_reset_o, RSTD_CYCLES))
		else $error("start-up delay too short");
	a_wdt_reset: assert property (
		$rose(timeout_flag_o) && !low_power_i |=> device_reset_o)
		else $error("timeout did not reset device");
	a_lp_pulse: assert property (
		$rose(timeout_flag_o) && low_power_i |-> ##[0:1] pc_sp_reset_o)
		else $error("low-power timeout gave no pc/sp reset");
	a_lp_keep: assert property (
		pc_sp_reset_o |-> timeout_flag_o && !device_reset_o ##1 !pc_sp_reset_o)
		else $error("pc/sp reset pulse wrong");
endmodule

bind wdrg_top wdrg_checker #(.RSTD_CYCLES(RSTD_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .low_power_i(low_power_i),
	.device_reset_o(device_reset_o), .por_reset_o(por_reset_o), .port_preset_o(port_preset_o),
	.pc_zero_o(pc_zero_o), .pc_sp_reset_o(pc_sp_reset_o), .timeout_flag_o(timeout_flag_o));

// File: sim/wdrg_top_tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// reset guard bench
// ---------------------------------------------------------------
module wdrg_top_tb_top import wdrg_pkg::*;;
	localparam int LD = 4;
	localparam int RD = 8;
	localparam logic [3:0] AC = WDRG_OFS_WDT_CTRL, AP = WDRG_OFS_PIN_KEY;
	localparam logic [3:0] AS = WDRG_OFS_STATUS, AM = WDRG_OFS_CMD;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, low_power_i, ext_nrst_pin_i, supply_drop_i;
	logic [3:0] adr_i;
	logic [31:0] dat_i, dat_o;
	logic ack_o, device_reset_o, por_reset_o, port_preset_o, pc_zero_o, pc_sp_reset_o;
	logic ext_pin_is_reset_o, timeout_flag_o;
	logic [15:0] lfsr_q = 16'h65FB;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int n_tests = 0;
	int cyc_cnt = 0;

	wdrg_top #(.LIRC_DIV(LD), .RSTD_CYCLES(RD)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .low_power_i(low_power_i), .ext_nrst_pin_i(ext_nrst_pin_i),
		.supply_drop_i(supply_drop_i), .device_reset_o(device_reset_o), .por_reset_o(por_reset_o),
		.port_preset_o(port_preset_o), .pc_zero_o(pc_zero_o), .pc_sp_reset_o(pc_sp_reset_o),
		.ext_pin_is_reset_o(ext_pin_is_reset_o), .timeout_flag_o(timeout_flag_o));

	function automatic logic [15:0] lfsr_nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_bit(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one bus cycle, held until ack, upper data bits random
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		lfsr_q = lfsr_nx(lfsr_q);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {lfsr_q, lfsr_q[7:0], d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wb_rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		wb(1'b0, a, 8'h00);
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task automatic wait_lv(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask

	// clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// read results against the oldest note
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
			chk(dat_o, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			$display("Error at %0t: run timed out", $time);
			end_of_test();
		end
	end

	initial begin
		int n;
		int e;
		logic [3:0] a;
		{rst_i, cyc_i, stb_i, we_i, low_power_i, supply_drop_i} = 6'h20;
		{adr_i, dat_i, ext_nrst_pin_i} = 37'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_bit(por_reset_o, 1'b1);
		chk_bit(ext_pin_is_reset_o, 1'b0);
		wb_rd(AC, 8'h53);
		wb_rd(AP, 8'h55);
		wb_rd(AS, 8'h00);
		wb_rd(AM, 8'h00);
		wb_rd(4'h6, 8'h00);
		chk_bit(por_reset_o, 1'b0);
		$display("test reset values done");
		for (int s = 0; s < 2; s++) begin
			cycles(12);
			wb(1'b1, AC, {WDRG_WDT_KEY_ON, 3'(s)});
			wb(1'b1, AM, 8'h01);
			wait_lv(timeout_flag_o, 1'b1, 5000, n);
			e = LD << (8 + 2 * s);
			chk_bit(n + 16 >= e && n <= e + 16, 1'b1);
			cycles(2);
			chk_bit(device_reset_o, 1'b1);
			wb_rd(AS, 8'h10);
			wb(1'b1, AM, 8'h01);
		end
		$display("test timeout ratios done");
		wb(1'b1, AC, 8'h50);
		for (int k = 0; k < 3; k++) begin
			cycles(700);
			wb(1'b1, AM, k[0] ? 8'h01 : 8'h02);
		end
		cycles(500);
		chk_bit(timeout_flag_o, 1'b0);
		wb(1'b1, AC, 8'hA8);
		cycles(1500);
		chk_bit(timeout_flag_o, 1'b0);
		$display("test clear and disable done");
		low_power_i <= 1'b1;
		wb(1'b1, AC, 8'h50);
		wb(1'b1, AM, 8'h01);
		wait_lv(pc_sp_reset_o, 1'b1, 1200, n);
		chk_bit(n < 1200 && timeout_flag_o === 1'b1, 1'b1);
		chk_bit(device_reset_o, 1'b0);
		wb(1'b1, AC, 8'hA8);
		low_power_i <= 1'b0;
		wb(1'b1, AM, 8'h01);
		$display("test low power done");
		for (int k = 0; k < 2; k++) begin
			a = k ? AP : AC;
			wb(1'b1, a, 8'h12);
			wait_lv(device_reset_o, 1'b1, 4 * LD, n);
			chk_bit(device_reset_o, 1'b1);
			chk_bit(n > 2 * LD && n <= 3 * LD, 1'b1);
			wb_rd(AS, k ? 8'h08 : 8'h01);
			wb_rd(a, k ? 8'h55 : 8'h53);
			wb(1'b1, AS, 8'hFF);
			wb_rd(AS, k ? 8'h08 : 8'h01);
			wb(1'b1, AS, 8'h00);
			wb_rd(AS, 8'h00);
			wb(1'b1, AC, 8'hA8);
		end
		$display("test key faults done");
		ext_nrst_pin_i <= 1'b0;
		cycles(20);
		chk_bit(device_reset_o, 1'b0);
		ext_nrst_pin_i <= 1'b1;
		cycles(6);
		wb(1'b1, AP, 8'hAA);
		chk_bit(ext_pin_is_reset_o, 1'b1);
		ext_nrst_pin_i <= 1'b0;
		wait_lv(device_reset_o, 1'b1, 10, n);
		chk_bit(device_reset_o, 1'b1);
		cycles(8 + lfsr_q[3:0]);
		ext_nrst_pin_i <= 1'b1;
		wait_lv(device_reset_o, 1'b0, RD + 20, n);
		chk_bit(n >= RD && n < RD + 20, 1'b1);
		wb_rd(AP, 8'hAA);
		$display("test reset pin done");
		supply_drop_i <= 1'b1;
		wait_lv(device_reset_o, 1'b1, 10, n);
		chk_bit(device_reset_o, 1'b1);
		supply_drop_i <= 1'b0;
		wait_lv(device_reset_o, 1'b0, RD + 20, n);
		chk_bit(device_reset_o, 1'b0);
		wb_rd(AP, 8'h55);
		cycles(3);
		$display("test supply drop done");
		// second power-on reset in mid-run: pin key must return to its reset value
		wb(1'b1, AP, 8'hAA);
		rst_i <= 1'b1;
		cycles(2);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_bit(por_reset_o, 1'b1);
		chk_bit(port_preset_o, 1'b1);
		chk_bit(pc_zero_o, 1'b1);
		wb_rd(AP, 8'h55);
		cycles(12);
		chk_bit(por_reset_o, 1'b0);
		$display("test power-on again done");
		chk(32'(exp_q.size()), 32'h0);
		end_of_test();
	end
endmodule
